// ===== rtl/dac_control.sv
// register block and channel pair of the two-channel 8-bit ladder converter
//
// Overview of operation
// - two channels, level equals reference times code/256
// - mode register: 8-bit, byte access, resets zero
// - enables at bits 5/4, modes bits 1/0
// - enable bit 0 stops channel, 1 allows
// - mode bit 0 write-triggered, 1 timer-triggered
// - channel 0 timer 2, channel 1 timer 3
// - code registers: 8-bit, byte access, reset zero
// - normal mode: code write starts conversion
// - normal mode: enabling converts the held code
// - output holds until next conversion
// - real-time mode: each timer event converts code
// - real-time output undefined until first event
// - deepest stop halts, outputs high impedance
// - idle and subclock modes keep converter running
`timescale 1ns/1ns
module dac_control #(
  parameter int unsigned SETTLE_CYCLES = dac_pkg::SETTLE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer2_compare_event,
  input  wire logic        timer3_compare_event,
  input  wire logic        stop_mode,
  input  wire logic        idle_standby_1,
  input  wire logic        idle_standby_2,
  input  wire logic        subclock_mode,
  output logic      [7:0]  analog_out_0,
  output logic             analog_out_0_oe,
  output logic      [7:0]  analog_out_1,
  output logic             analog_out_1_oe
);

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [7:0] mode_r;
  logic [7:0] code0_r;
  logic [7:0] code1_r;
  logic [7:0] mode_nxt;
  logic       pready_r;
  logic       pslverr_r;
  logic [31:0] prdata_r;
  logic [7:0] level0;
  logic [7:0] level1;
  logic       drive0;
  logic       drive1;
  logic       settled0;
  logic       settled1;
  logic       defined0;
  logic       defined1;

  // ==========================================================================
  // address decode
  // ==========================================================================
  function automatic dac_pkg::reg_sel_t decode(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    if (addr[1:0] != 2'b00) begin
      decode = dac_pkg::SEL_NONE;
    end else if (idx == dac_pkg::MODE_INDEX) begin
      decode = dac_pkg::SEL_MODE;
    end else if (idx == dac_pkg::CODE0_INDEX) begin
      decode = dac_pkg::SEL_CODE0;
    end else if (idx == dac_pkg::CODE1_INDEX) begin
      decode = dac_pkg::SEL_CODE1;
    end else if (idx == dac_pkg::STAT_INDEX) begin
      decode = dac_pkg::SEL_STAT;
    end else begin
      decode = dac_pkg::SEL_NONE;
    end
  endfunction

  wire dac_pkg::reg_sel_t sel = decode(paddr);
  wire       setup     = psel & ~penable;
  // the access edge is the only one at which a write lands
  wire       access    = psel & penable & pready_r;
  // only the low byte lane carries register data; other lanes alone do nothing
  wire       lane0     = pstrb[0];
  wire       wr_ok     = access & pwrite & lane0 & ~pslverr_r;
  wire       wr_mode   = wr_ok & (sel == dac_pkg::SEL_MODE);
  wire       wr_code0  = wr_ok & (sel == dac_pkg::SEL_CODE0);
  wire       wr_code1  = wr_ok & (sel == dac_pkg::SEL_CODE1);
  wire [7:0] wdata     = pwdata[7:0];

  // fixed-zero bits are masked on the way in, so they always read back zero
  assign mode_nxt = wdata & dac_pkg::MODE_WMASK;

  // ==========================================================================
  // mode field views
  // ==========================================================================
  wire ce0 = mode_r[dac_pkg::CE0_BIT];
  wire ce1 = mode_r[dac_pkg::CE1_BIT];
  wire md0 = mode_r[dac_pkg::MD0_BIT];
  wire md1 = mode_r[dac_pkg::MD1_BIT];

  // the enable bit moves in the same edge as a mode write, so the channel sees
  // the new enable one cycle later and detects its rise against its own copy
  wire low_power = idle_standby_1 | idle_standby_2 | subclock_mode;

  // ==========================================================================
  // status view
  // ==========================================================================
  wire [7:0] status_val;
  assign status_val[dac_pkg::ST_SETTLED0] = settled0;
  assign status_val[dac_pkg::ST_SETTLED1] = settled1;
  assign status_val[3:2]                  = 2'b00;
  assign status_val[dac_pkg::ST_DEFINED0] = defined0;
  assign status_val[dac_pkg::ST_DEFINED1] = defined1;
  assign status_val[dac_pkg::ST_LOWPOWER] = low_power;
  assign status_val[dac_pkg::ST_STOP]     = stop_mode;

  wire [7:0] rd_byte = (sel == dac_pkg::SEL_MODE)  ? mode_r  :
                       (sel == dac_pkg::SEL_CODE0) ? code0_r :
                       (sel == dac_pkg::SEL_CODE1) ? code1_r :
                       (sel == dac_pkg::SEL_STAT)  ? status_val : 8'h00;
  wire       bad_addr = (sel == dac_pkg::SEL_NONE);
  // status is read only; a write to it is answered with an error
  wire       bad_wr   = pwrite & (sel == dac_pkg::SEL_STAT);

  // ==========================================================================
  // apb answer: ready, data and error are all set up in the setup cycle
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & (bad_addr | bad_wr);
      if (setup && !pwrite) begin
        prdata_r <= {24'h000000, rd_byte};
      end else if (access) begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ==========================================================================
  // software registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= dac_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code0_r <= dac_pkg::CODE_RESET;
      code1_r <= dac_pkg::CODE_RESET;
    end else begin
      if (wr_code0) begin
        code0_r <= wdata;
      end
      if (wr_code1) begin
        code1_r <= wdata;
      end
    end
  end

  // ==========================================================================
  // channels; idle and subclock inputs do not gate them
  // ==========================================================================
  dac_channel #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_ch0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (ce0),
    .rt_mode   (md0),
    .stop_mode (stop_mode),
    .code      (code0_r),
    .code_wr   (wr_code0),
    .wr_code   (wdata),
    .timer_evt (timer2_compare_event),
    .level_r   (level0),
    .drive_r   (drive0),
    .settled_r (settled0),
    .defined_r (defined0)
  );

  dac_channel #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_ch1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (ce1),
    .rt_mode   (md1),
    .stop_mode (stop_mode),
    .code      (code1_r),
    .code_wr   (wr_code1),
    .wr_code   (wdata),
    .timer_evt (timer3_compare_event),
    .level_r   (level1),
    .drive_r   (drive1),
    .settled_r (settled1),
    .defined_r (defined1)
  );

  // ladder inputs are flip-flop outputs inside the channels
  assign analog_out_0    = level0;
  assign analog_out_0_oe = drive0;
  assign analog_out_1    = level1;
  assign analog_out_1_oe = drive1;

endmodule

// ===== include/dac_pkg.sv
// shared constants and types for the two-channel ladder converter control
package dac_pkg;

  // ==========================================================================
  // register map: printed offsets are word indices, byte address = index * 4
  // ==========================================================================
  localparam int unsigned IDX_W       = 30;
  localparam logic [29:0] MODE_INDEX  = 30'h0FFFF282;
  localparam logic [29:0] CODE0_INDEX = 30'h0FFFF284;
  localparam logic [29:0] CODE1_INDEX = 30'h0FFFF285;
  localparam logic [29:0] STAT_INDEX  = 30'h0FFFF286;

  // ==========================================================================
  // mode register fields
  // ==========================================================================
  localparam int unsigned CE1_BIT    = 5;
  localparam int unsigned CE0_BIT    = 4;
  localparam int unsigned MD1_BIT    = 1;
  localparam int unsigned MD0_BIT    = 0;
  localparam logic [7:0]  MODE_WMASK = 8'h33;
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [7:0]  CODE_RESET = 8'h00;

  // ==========================================================================
  // status register fields (read only)
  // ==========================================================================
  localparam int unsigned ST_SETTLED0 = 0;
  localparam int unsigned ST_SETTLED1 = 1;
  localparam int unsigned ST_DEFINED0 = 4;
  localparam int unsigned ST_DEFINED1 = 5;
  localparam int unsigned ST_LOWPOWER = 6;
  localparam int unsigned ST_STOP     = 7;

  // ==========================================================================
  // timing: settling is a longest time, so the cycle count rounds down
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SETTLE_TIME_NS = 3000;
  localparam int unsigned SETTLE_CYCLES  =
    (SETTLE_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (SETTLE_TIME_NS / CLK_PERIOD_NS);

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    CH_OFF      = 2'b00,
    CH_WAIT_TRG = 2'b01,
    CH_SETTLING = 2'b10,
    CH_STEADY   = 2'b11
  } ch_state_t;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_MODE  = 3'b001,
    SEL_CODE0 = 3'b010,
    SEL_CODE1 = 3'b011,
    SEL_STAT  = 3'b100
  } reg_sel_t;

endpackage

// ===== rtl/dac_channel.sv
// one converter channel: trigger selection, held output level, settling timer
`timescale 1ns/1ns
module dac_channel #(
  parameter int unsigned SETTLE_CYCLES = dac_pkg::SETTLE_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       rt_mode,
  input  wire logic       stop_mode,
  input  wire logic [7:0] code,
  input  wire logic       code_wr,
  input  wire logic [7:0] wr_code,
  input  wire logic       timer_evt,
  output logic      [7:0] level_r,
  output logic            drive_r,
  output logic            settled_r,
  output logic            defined_r
);

  localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SETTLE_CYCLES - 1);

  dac_pkg::ch_state_t state_r;
  dac_pkg::ch_state_t state_nxt;
  logic [CNT_W-1:0]   cnt_r;
  logic               enable_d_r;

  // ==========================================================================
  // trigger sources
  // ==========================================================================
  wire       active       = enable & ~stop_mode;
  wire       enable_rise  = enable & ~enable_d_r;
  wire       start_normal = active & ~rt_mode & (code_wr | enable_rise);
  wire       start_rt     = active & rt_mode & timer_evt;
  wire       start        = start_normal | start_rt;
  // a write in the trigger cycle converts the new value; software avoids that case
  wire [7:0] start_val    = code_wr ? wr_code : code;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dac_pkg::CH_OFF: begin
        if (active && rt_mode && enable_rise) begin
          state_nxt = dac_pkg::CH_WAIT_TRG;
        end else if (active) begin
          state_nxt = dac_pkg::CH_STEADY;
        end
      end
      dac_pkg::CH_WAIT_TRG,
      dac_pkg::CH_STEADY: begin
        if (!active) begin
          state_nxt = dac_pkg::CH_OFF;
        end
      end
      dac_pkg::CH_SETTLING: begin
        if (!active) begin
          state_nxt = dac_pkg::CH_OFF;
        end else if (cnt_r == '0) begin
          state_nxt = dac_pkg::CH_STEADY;
        end
      end
      default: state_nxt = dac_pkg::CH_OFF;
    endcase
    if (start) begin
      state_nxt = dac_pkg::CH_SETTLING;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= dac_pkg::CH_OFF;
      cnt_r      <= '0;
      enable_d_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      enable_d_r <= enable;
      if (start) begin
        cnt_r <= CNT_LOAD;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // level only moves on a conversion start and is held otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r   <= dac_pkg::CODE_RESET;
      drive_r   <= 1'b0;
      settled_r <= 1'b0;
      defined_r <= 1'b0;
    end else begin
      if (start) begin
        level_r <= start_val;
      end
      drive_r   <= active;
      settled_r <= (state_nxt == dac_pkg::CH_STEADY);
      if (start) begin
        defined_r <= 1'b1;
      end else if (active && rt_mode && enable_rise) begin
        defined_r <= 1'b0;
      end
    end
  end

endmodule

// ===== dv/dac_load_model.sv
// analog load on both converter pins, seen as a level in millivolts
`timescale 1ns/1ns
module dac_load_model #(
  parameter int unsigned REF_MV = 3300
) (
  input  wire logic        pclk,
  input  wire logic [7:0]  analog_out_0,
  input  wire logic        analog_out_0_oe,
  input  wire logic [7:0]  analog_out_1,
  input  wire logic        analog_out_1_oe,
  output logic      [15:0] load_mv_0,
  output logic      [15:0] load_mv_1
);
  // ==========================================================================
  // pin levels
  // ==========================================================================
  logic float_r = 1'b0;

  // a released pin wanders, so a stale level never passes for a driven one
  always @(posedge pclk) begin
    float_r <= ~float_r;
  end

  assign load_mv_0 = analog_out_0_oe ? 16'((REF_MV * analog_out_0) / 256) : {16{float_r}};
  assign load_mv_1 = analog_out_1_oe ? 16'((REF_MV * analog_out_1) / 256) : {16{float_r}};
endmodule

// ===== dv/dac_control_sva.sv
// port-level checker for the two-channel converter control
`timescale 1ns/1ns
module dac_control_sva #(
  parameter int unsigned SETTLE_CYCLES = dac_pkg::SETTLE_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer2_compare_event,
  input wire logic        timer3_compare_event,
  input wire logic        stop_mode,
  input wire logic        idle_standby_1,
  input wire logic        idle_standby_2,
  input wire logic        subclock_mode,
  input wire logic [7:0]  analog_out_0,
  input wire logic        analog_out_0_oe,
  input wire logic [7:0]  analog_out_1,
  input wire logic        analog_out_1_oe
);
  // ==========================================================================
  // shadow of the register writes
  // ==========================================================================
  localparam logic [31:0] A_MODE = {dac_pkg::MODE_INDEX, 2'b00};
  localparam logic [31:0] A_C0   = {dac_pkg::CODE0_INDEX, 2'b00};
  localparam logic [31:0] A_C1   = {dac_pkg::CODE1_INDEX, 2'b00};
  logic [7:0] mode_r;
  logic [7:0] code0_r;
  logic [7:0] code1_r;
  wire        w_acc  = psel && penable && pready && pwrite && pstrb[0];
  wire        w_mode = w_acc && (paddr == A_MODE);
  wire        w_c0   = w_acc && (paddr == A_C0);
  wire        w_c1   = w_acc && (paddr == A_C1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r  <= 8'h00;
      code0_r <= 8'h00;
      code1_r <= 8'h00;
    end else begin
      if (w_mode) mode_r <= pwdata[7:0] & dac_pkg::MODE_WMASK;
      if (w_c0) code0_r <= pwdata[7:0];
      if (w_c1) code1_r <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_en0_rise;
    w_mode && pwdata[4] && !pwdata[0] && !mode_r[4] && !stop_mode ##1 !stop_mode;
  endsequence

  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_MODE_ZERO_BITS: assert property (pready && !pwrite && paddr == A_MODE
    |-> (prdata[7:0] & ~dac_pkg::MODE_WMASK) == 8'h00) else $error("fixed mode bit set");
  AST_OE_LAG: assert property (1 |=> analog_out_0_oe == $past(mode_r[4] && !stop_mode))
    else $error("pin drive does not follow enable");
  AST_STOP_HIZ: assert property (stop_mode |=> !analog_out_1_oe)
    else $error("pin driven in stop");
  AST_NORMAL_WRITE: assert property (w_c0 && mode_r[4] && !mode_r[0] && !stop_mode
    |=> analog_out_0 == $past(pwdata[7:0])) else $error("code write not converted");
  AST_ENABLE_CONVERT: assert property (s_en0_rise |=> analog_out_0 == $past(code0_r, 2))
    else $error("enable did not convert held code");
  AST_RT_TRIGGER: assert property (timer3_compare_event && mode_r[5] && mode_r[1]
    && !stop_mode && !w_c1 |=> analog_out_1 == $past(code1_r)) else $error("trigger missed");
  AST_HOLD_0: assert property ($changed(analog_out_0)
    |-> $past(w_c0 || timer2_compare_event) || $past(w_mode, 2)) else $error("level moved");
endmodule

// ===== dv/test_dual_channel_dac_control.sv
// self-checking bench for the two-channel converter control
`timescale 1ns/1ns
module test_dual_channel_dac_control;
  // ==========================================================================
  // signals and tasks
  // ==========================================================================
  localparam int          MV     = 3300;
  localparam logic [31:0] A_MODE = {dac_pkg::MODE_INDEX, 2'b00};
  localparam logic [31:0] A_C0   = {dac_pkg::CODE0_INDEX, 2'b00};
  localparam logic [31:0] A_C1   = {dac_pkg::CODE1_INDEX, 2'b00};
  localparam logic [31:0] A_ST   = {dac_pkg::STAT_INDEX, 2'b00};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        timer2_compare_event = 1'b0;
  logic        timer3_compare_event = 1'b0;
  logic        stop_mode = 1'b0;
  logic        idle = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  analog_out_0;
  logic        analog_out_0_oe;
  logic [7:0]  analog_out_1;
  logic        analog_out_1_oe;
  logic [15:0] mv0;
  logic [15:0] mv1;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #50 pclk = ~pclk;

  dac_control #(.SETTLE_CYCLES(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer2_compare_event(timer2_compare_event), .timer3_compare_event(timer3_compare_event),
    .stop_mode(stop_mode), .idle_standby_1(idle), .idle_standby_2(idle), .subclock_mode(idle),
    .analog_out_0(analog_out_0), .analog_out_0_oe(analog_out_0_oe),
    .analog_out_1(analog_out_1), .analog_out_1_oe(analog_out_1_oe));
  dac_load_model #(.REF_MV(MV)) u_load (.pclk(pclk), .analog_out_0(analog_out_0),
    .analog_out_0_oe(analog_out_0_oe), .analog_out_1(analog_out_1),
    .analog_out_1_oe(analog_out_1_oe), .load_mv_0(mv0), .load_mv_1(mv1));

  task automatic close_out;
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, 4'hF);
    chk(rd, {24'h0, e});
  endtask

  // a pulse lasts one edge; two more edges let the new level show
  task automatic pulse(input logic ch);
    if (ch) timer3_compare_event <= 1'b1;
    else timer2_compare_event <= 1'b1;
    @(posedge pclk);
    timer2_compare_event <= 1'b0;
    timer3_compare_event <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic pin(input logic ch, input logic oe, input logic [7:0] e);
    chk({31'h0, ch ? analog_out_1_oe : analog_out_0_oe}, {31'h0, oe});
    if (oe) begin
      chk({24'h0, ch ? analog_out_1 : analog_out_0}, {24'h0, e});
      chk({16'h0, ch ? mv1 : mv0}, (MV * e) / 256);
    end
  endtask

  // ==========================================================================
  // timeout and main sequence
  // ==========================================================================
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out;
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(A_MODE, 8'h00);
    rd_chk(A_C0, 8'h00);
    rd_chk(A_C1, 8'h00);
    apb(1'b0, A_MODE + 32'h4, 8'h00, 4'hF);
    chk({31'h0, er}, 32'h1);
    wr(A_MODE, 8'hCC);
    rd_chk(A_MODE, 8'h00);
    wr(A_C0, 8'hA5);
    pin(1'b0, 1'b0, 8'h00);
    wr(A_MODE, 8'h10);
    repeat (2) @(posedge pclk);
    pin(1'b0, 1'b1, 8'hA5);
    wr(A_C0, 8'hFF);
    pin(1'b0, 1'b1, 8'hFF);
    wr(A_C0, 8'h00);
    pin(1'b0, 1'b1, 8'h00);
    pulse(1'b0);
    repeat (5) @(posedge pclk);
    pin(1'b0, 1'b1, 8'h00);
    apb(1'b1, A_C0, 8'h5A, 4'hE);
    rd_chk(A_C0, 8'h00);
    wr(A_MODE, 8'h12);
    wr(A_C1, 8'h3C);
    wr(A_MODE, 8'h32);
    pulse(1'b0);
    pulse(1'b1);
    pin(1'b1, 1'b1, 8'h3C);
    wr(A_C1, 8'h77);
    pin(1'b1, 1'b1, 8'h3C);
    pulse(1'b1);
    pin(1'b1, 1'b1, 8'h77);
    idle <= 1'b1;
    wr(A_C0, 8'h81);
    pin(1'b0, 1'b1, 8'h81);
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    pin(1'b0, 1'b0, 8'h00);
    pin(1'b1, 1'b0, 8'h00);
    // stop and idle flags set, both channels defined but no longer settled
    rd_chk(A_ST, 8'hF0);
    apb(1'b1, A_ST, 8'hFF, 4'hF);
    chk({31'h0, er}, 32'h1);
    wr(A_C0, 8'h42);
    pulse(1'b1);
    stop_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    pin(1'b0, 1'b1, 8'h81);
    pin(1'b1, 1'b1, 8'h77);
    wr(A_MODE, 8'h22);
    wr(A_MODE, 8'h23);
    wr(A_MODE, 8'h33);
    pulse(1'b0);
    pin(1'b0, 1'b1, 8'h42);
    rd_chk(A_ST, 8'h73);
    // a second reset in mid-run must clear what software has written
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(A_MODE, 8'h00);
    rd_chk(A_C0, 8'h00);
    pin(1'b0, 1'b0, 8'h00);
    close_out;
  end
endmodule

bind dac_control dac_control_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer2_compare_event(timer2_compare_event), .timer3_compare_event(timer3_compare_event),
  .stop_mode(stop_mode), .idle_standby_1(idle_standby_1), .idle_standby_2(idle_standby_2),
  .subclock_mode(subclock_mode), .analog_out_0(analog_out_0),
  .analog_out_0_oe(analog_out_0_oe), .analog_out_1(analog_out_1),
  .analog_out_1_oe(analog_out_1_oe));
